// ---- cmpev_top.sv ----
// Comparator channel control, event flag and register slave
//
// Summary of operation
// - Pin enable drives result onto output pin while channel is enabled
// - Polarity bit inverts result for all uses
// - Mode bit selects op amp or comparator
// - Op amp mode never drives output pin
// - Edge sets sticky flag, blocks further events
// - Result status bit reads polarity-adjusted compare
// - Edge code 11 fires on any change
// - Edge code 10 fires on falling adjusted
// - Edge code 01 fires on rising adjusted
// - Edge code 00 never fires
// - Reference bit routes internal reference or pin
// - Channel field picks negative pin one/two
// - Unimplemented control bits read zero
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module cmpev_top (
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_i,
    input  wire logic [cmpev_pkg::ADDR_W-1:0] bus_addr_i,
    input  wire logic [cmpev_pkg::DATA_W-1:0] bus_wdata_i,
    input  wire logic                     bus_wr_i,
    input  wire logic                     bus_rd_i,
    output logic      [cmpev_pkg::DATA_W-1:0] bus_rdata_o,
    input  wire logic                     raw_compare_i,
    output logic                          comparator_output_pin_o,
    output logic                          comparator_output_pin_oe_n_o,
    output cmpev_pkg::cmpev_analog_t      analog_ctrl_o,
    output logic                          trigger_o,
    output logic                          irq_o
);
    import cmpev_pkg::*;

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        cmpev_cfg_t        cfg;
        logic              sticky_event_flag;
        logic [IRQ_W-1:0]  irq_status;
        logic [IRQ_W-1:0]  irq_enable;
        logic [DATA_W-1:0] rdata;
        logic              trigger;
        logic              pin;
        logic              pin_oe_n;
        cmpev_analog_t     analog;
    } cmpev_state_t;

    cmpev_state_t   st_r;
    cmpev_state_t   st_nxt;
    cmpev_bus_req_t req;
    logic           synced;
    logic           compare_result;
    logic           fire;
    logic           arm;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] b);
        hit = (a == b);
    endfunction

    function automatic logic [DATA_W-1:0] pack_control(
        input cmpev_cfg_t c, input logic ev, input logic res);
        logic [DATA_W-1:0] v;
        v               = '0;
        v[BIT_ENABLE]   = c.channel_enable;
        v[BIT_PIN_EN]   = c.output_pin_enable;
        v[BIT_INVERT]   = c.output_invert;
        v[BIT_AMP_MODE] = c.amplifier_mode_select;
        v[BIT_EVENT]    = ev;
        v[BIT_RESULT]   = res;
        v[BIT_EDGE_HI]  = c.edge_select[1];
        v[BIT_EDGE_LO]  = c.edge_select[0];
        v[BIT_REF_SEL]  = c.reference_select;
        v[BIT_NEG_HI]   = c.negative_input_select[1];
        v[BIT_NEG_LO]   = c.negative_input_select[0];
        pack_control    = v;
    endfunction

    assign req.wr    = bus_wr_i;
    assign req.rd    = bus_rd_i;
    assign req.addr  = bus_addr_i;
    assign req.wdata = bus_wdata_i;

    // ********************************************************************
    // Compare path
    // ********************************************************************
    cmpev_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .async_i    (raw_compare_i),
        .level_o    (synced)
    );

    // Disabled channel holds result low
    assign compare_result = st_r.cfg.channel_enable &
                            (synced ^ st_r.cfg.output_invert);

    // Flag blocks detection entirely while set
    assign arm = st_r.cfg.channel_enable & ~st_r.sticky_event_flag;

    cmpev_edge u_edge (
        .core_clk_i    (core_clk_i),
        .rst_i         (rst_i),
        .level_i       (compare_result),
        .arm_i         (arm),
        .edge_select_i (st_r.cfg.edge_select),
        .fire_o        (fire)
    );

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        logic [DATA_W-1:0] w;
        w      = req.wdata & CONTROL_WMASK;
        st_nxt = st_r;
        st_nxt.rdata   = '0;
        st_nxt.trigger = fire;

        if (req.wr && hit(req.addr, CONTROL_ADDR)) begin
            st_nxt.cfg.channel_enable        = w[BIT_ENABLE];
            st_nxt.cfg.output_pin_enable     = w[BIT_PIN_EN];
            st_nxt.cfg.output_invert         = w[BIT_INVERT];
            st_nxt.cfg.amplifier_mode_select = w[BIT_AMP_MODE];
            st_nxt.cfg.edge_select           = w[BIT_EDGE_HI:BIT_EDGE_LO];
            st_nxt.cfg.reference_select      = w[BIT_REF_SEL];
            st_nxt.cfg.negative_input_select = w[BIT_NEG_HI:BIT_NEG_LO];
            // Software may clear or set the flag; writing zero re-arms
            st_nxt.sticky_event_flag         = w[BIT_EVENT];
        end
        if (req.wr && hit(req.addr, IRQ_ENABLE_ADDR)) begin
            st_nxt.irq_enable = req.wdata[IRQ_W-1:0];
        end
        if (req.wr && hit(req.addr, IRQ_CLEAR_ADDR)) begin
            st_nxt.irq_status = st_r.irq_status & ~req.wdata[IRQ_W-1:0];
        end

        // Hardware set wins over a same-cycle software clear
        if (fire) begin
            st_nxt.sticky_event_flag = 1'b1;
            st_nxt.irq_status[0]     = 1'b1;
        end

        if (req.rd) begin
            if (hit(req.addr, CONTROL_ADDR)) begin
                st_nxt.rdata = pack_control(st_r.cfg, st_r.sticky_event_flag,
                                            compare_result);
            end else if (hit(req.addr, IRQ_STATUS_ADDR)) begin
                st_nxt.rdata[IRQ_W-1:0] = st_r.irq_status;
            end else if (hit(req.addr, IRQ_ENABLE_ADDR)) begin
                st_nxt.rdata[IRQ_W-1:0] = st_r.irq_enable;
            end
        end

        // Pin follows result only in comparator mode with pin enabled
        st_nxt.pin_oe_n = ~(st_r.cfg.channel_enable &
                            st_r.cfg.output_pin_enable &
                            ~st_r.cfg.amplifier_mode_select);
        st_nxt.pin      = ~st_nxt.pin_oe_n & compare_result;

        st_nxt.analog.channel_on        = st_r.cfg.channel_enable;
        st_nxt.analog.amp_mode          = st_r.cfg.amplifier_mode_select;
        st_nxt.analog.pos_use_reference = st_r.cfg.reference_select;
        // Unimplemented channel codes connect neither pin
        st_nxt.analog.neg_use_pin_one   =
            (st_r.cfg.negative_input_select == NEG_PIN_ONE);
        st_nxt.analog.neg_use_pin_two   =
            (st_r.cfg.negative_input_select == NEG_PIN_TWO);
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r            <= '0;
            st_r.irq_status <= IRQ_RESET;
            st_r.irq_enable <= IRQ_RESET;
            st_r.pin_oe_n   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign bus_rdata_o                  = st_r.rdata;
    assign comparator_output_pin_o      = st_r.pin;
    assign comparator_output_pin_oe_n_o = st_r.pin_oe_n;
    assign analog_ctrl_o                = st_r.analog;
    assign trigger_o                    = st_r.trigger;
    assign irq_o = |(st_r.irq_status & st_r.irq_enable);
endmodule // cmpev_top
`default_nettype wire

// ---- cmpev_pkg.sv ----
// Package: constants and types for the comparator event control block
package cmpev_pkg;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam int unsigned  ADDR_W          = 4;
    localparam int unsigned  DATA_W          = 16;
    localparam logic [3:0]   CONTROL_ADDR    = 4'h0;
    localparam logic [3:0]   IRQ_STATUS_ADDR = 4'h4;
    localparam logic [3:0]   IRQ_CLEAR_ADDR  = 4'h8;
    localparam logic [3:0]   IRQ_ENABLE_ADDR = 4'hC;

    // ********************************************************************
    // Control field positions
    // ********************************************************************
    localparam int unsigned  BIT_ENABLE      = 15;
    localparam int unsigned  BIT_PIN_EN      = 14;
    localparam int unsigned  BIT_INVERT      = 13;
    localparam int unsigned  BIT_AMP_MODE    = 10;
    localparam int unsigned  BIT_EVENT       = 9;
    localparam int unsigned  BIT_RESULT      = 8;
    localparam int unsigned  BIT_EDGE_HI     = 7;
    localparam int unsigned  BIT_EDGE_LO     = 6;
    localparam int unsigned  BIT_REF_SEL     = 4;
    localparam int unsigned  BIT_NEG_HI      = 1;
    localparam int unsigned  BIT_NEG_LO      = 0;
    localparam logic [15:0]  CONTROL_WMASK   = 16'hE6D3;
    localparam logic [15:0]  CONTROL_RESET   = 16'h0000;

    // ********************************************************************
    // Encodings
    // ********************************************************************
    localparam logic [1:0]   EDGE_NONE       = 2'h0;
    localparam logic [1:0]   EDGE_RISE       = 2'h1;
    localparam logic [1:0]   EDGE_FALL       = 2'h2;
    localparam logic [1:0]   EDGE_ANY        = 2'h3;
    localparam logic [1:0]   NEG_PIN_ONE     = 2'h0;
    localparam logic [1:0]   NEG_PIN_TWO     = 2'h1;
    localparam int unsigned  IRQ_W           = 1;
    localparam logic [0:0]   IRQ_RESET       = 1'h0;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } cmpev_bus_req_t;

    typedef struct packed {
        logic                channel_enable;
        logic                output_pin_enable;
        logic                output_invert;
        logic                amplifier_mode_select;
        logic [1:0]          edge_select;
        logic                reference_select;
        logic [1:0]          negative_input_select;
    } cmpev_cfg_t;

    typedef struct packed {
        logic                pos_use_reference;
        logic                neg_use_pin_one;
        logic                neg_use_pin_two;
        logic                amp_mode;
        logic                channel_on;
    } cmpev_analog_t;

endpackage : cmpev_pkg

// ---- cmpev_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module cmpev_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic async_i,
    output logic      level_o
);
    import cmpev_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } cmpev_sync_state_t;

    cmpev_sync_state_t st_r;
    cmpev_sync_state_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = async_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Only the second and third stage vote; the first is metastable
        if (st_r.s2 == st_r.s3) begin
            st_nxt.level = st_r.s3;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.level;
endmodule // cmpev_sync
`default_nettype wire

// ---- cmpev_edge.sv ----
// Edge detector selecting rising, falling or any change
`timescale 1ns/1ps
`default_nettype none
module cmpev_edge (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       level_i,
    input  wire logic       arm_i,
    input  wire logic [1:0] edge_select_i,
    output logic            fire_o
);
    import cmpev_pkg::*;

    typedef struct packed {
        logic prev;
        logic armed;
    } cmpev_edge_state_t;

    cmpev_edge_state_t st_r;
    cmpev_edge_state_t st_nxt;
    logic              rise;
    logic              fall;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.prev  = level_i;
        st_nxt.armed = arm_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Armed delay hides the edge seen when the channel is first enabled
    assign rise = arm_i & st_r.armed & level_i & ~st_r.prev;
    assign fall = arm_i & st_r.armed & ~level_i & st_r.prev;

    always_comb begin
        unique case (edge_select_i)
            EDGE_NONE: fire_o = 1'b0;
            EDGE_RISE: fire_o = rise;
            EDGE_FALL: fire_o = fall;
            EDGE_ANY:  fire_o = rise | fall;
        endcase
    end
endmodule // cmpev_edge
`default_nettype wire

// ---- cmpev_chk.sv ----
// Checker: port-level properties of the comparator event block
`timescale 1ns/1ps
`default_nettype none
module cmpev_chk (
    input wire logic                         core_clk_i,
    input wire logic                         rst_i,
    input wire logic [cmpev_pkg::ADDR_W-1:0] bus_addr_i,
    input wire logic [cmpev_pkg::DATA_W-1:0] bus_wdata_i,
    input wire logic                         bus_wr_i,
    input wire logic                         bus_rd_i,
    input wire logic [cmpev_pkg::DATA_W-1:0] bus_rdata_o,
    input wire logic                         raw_compare_i,
    input wire logic                         comparator_output_pin_o,
    input wire logic                         comparator_output_pin_oe_n_o,
    input wire cmpev_pkg::cmpev_analog_t     analog_ctrl_o,
    input wire logic                         trigger_o,
    input wire logic                         irq_o
);
    import cmpev_pkg::*;
    logic [15:0] ctrl_r;
    logic        irq_en_r;
    // ********
    // Shadow of software writes
    // ********
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl_r   <= '0;
            irq_en_r <= 1'b0;
        end else if (bus_wr_i && bus_addr_i == CONTROL_ADDR) begin
            ctrl_r <= bus_wdata_i & CONTROL_WMASK;
        end else if (bus_wr_i && bus_addr_i == IRQ_ENABLE_ADDR) begin
            irq_en_r <= bus_wdata_i[0];
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // ********
    // Properties
    // ********
    amp_pin_off_a: assert property (
        analog_ctrl_o.amp_mode |-> comparator_output_pin_oe_n_o)
        else $error("pin driven in amplifier mode");
    pin_drive_a: assert property (
        !comparator_output_pin_oe_n_o |-> analog_ctrl_o.channel_on)
        else $error("pin driven while channel off");
    undriven_low_a: assert property (
        comparator_output_pin_oe_n_o |-> !comparator_output_pin_o)
        else $error("undriven pin not low");
    trig_single_a: assert property (
        trigger_o |=> !trigger_o [*2])
        else $error("event repeated while flag set");
    off_no_trig_a: assert property (
        !analog_ctrl_o.channel_on |-> !trigger_o)
        else $error("event from disabled channel");
    // Code change lands one cycle before its trigger can show
    edge_none_a: assert property (
        ctrl_r[7:6] == EDGE_NONE && $past(ctrl_r[7:6]) == EDGE_NONE
        |-> !trigger_o) else $error("event with edge code none");
    irq_follow_a: assert property (
        trigger_o && irq_en_r |-> irq_o)
        else $error("enabled event without interrupt");
    irq_mask_a: assert property (
        !irq_en_r |-> !irq_o) else $error("masked interrupt raised");
    analog_route_a: assert property (
        !$past(rst_i) |-> analog_ctrl_o == {$past(ctrl_r[4]),
        $past(ctrl_r[1:0]) == NEG_PIN_ONE, $past(ctrl_r[1:0]) ==
        NEG_PIN_TWO, $past(ctrl_r[10]), $past(ctrl_r[15])})
        else $error("analog routing mismatch");
endmodule // cmpev_chk
`default_nettype wire

// ---- cmpev_afe.sv ----
// Partner: behavioural analog comparator front end
`timescale 1ns/1ps
`default_nettype none
module cmpev_afe (
    input  wire logic                     core_clk_i,
    input  wire cmpev_pkg::cmpev_analog_t ctl_i,
    input  wire logic [7:0]               pos_one_i,
    input  wire logic [7:0]               vref_i,
    input  wire logic [7:0]               neg_one_i,
    input  wire logic [7:0]               neg_two_i,
    output logic                          raw_o
);
    import cmpev_pkg::*;
    logic       noise_r = 1'b0;
    logic [7:0] vp;
    logic [7:0] vn;
    // Powered-down front end chatters; the block must ignore it
    always @(posedge core_clk_i) noise_r <= ~noise_r;
    assign vp = ctl_i.pos_use_reference ? vref_i : pos_one_i;
    // Unavailable inputs are tied to ground
    assign vn = ctl_i.neg_use_pin_one ? neg_one_i :
                (ctl_i.neg_use_pin_two ? neg_two_i : 8'h00);
    assign raw_o = ctl_i.channel_on ? (vp > vn) : noise_r;
endmodule // cmpev_afe
`default_nettype wire

// ---- cmpev_top_tb.sv ----
// Testbench: self-checking bench for the comparator event block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module cmpev_top_tb;
    import cmpev_pkg::*;
    logic          core_clk_i = 1'b0;
    logic          rst_i = 1'b1;
    logic [3:0]    addr;
    logic [15:0]   wdata, rdata, d;
    logic          wr, rd, raw, pin, oe_n, trig, irq;
    cmpev_analog_t actl;
    logic [7:0]    p1, vr, n1, n2;
    logic [2:0]    tbl [4] = '{3'b101, 3'b001, 3'b100, 3'b110};
    integer        seed = 32'hB90DB2C8;
    int            fails = 0, checked = 0, n, e1, e2, b, inv, code;
    always #10 core_clk_i = ~core_clk_i;
    cmpev_top cmpev_top_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr),
        .bus_rd_i(rd), .bus_rdata_o(rdata), .raw_compare_i(raw),
        .comparator_output_pin_o(pin), .comparator_output_pin_oe_n_o(oe_n),
        .analog_ctrl_o(actl), .trigger_o(trig), .irq_o(irq));
    cmpev_afe cmpev_afe_inst (.core_clk_i(core_clk_i), .ctl_i(actl),
        .pos_one_i(p1), .vref_i(vr), .neg_one_i(n1), .neg_two_i(n2),
        .raw_o(raw));
    // ********
    // Bus and stimulus tasks
    // ********
    task automatic bw(input logic [3:0] a, input logic [15:0] v);
        @(posedge core_clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk_i);
        wr <= 1'b0;
    endtask
    task automatic br(input logic [3:0] a);
        @(posedge core_clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk_i);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic set_in(input int pp, input int rr, input int q1,
                          input int q2);
        @(posedge core_clk_i);
        b = $random(seed) & 8'h3F;
        p1 <= 8'(b + pp);
        vr <= 8'(b + rr);
        n1 <= 8'(b + q1);
        n2 <= 8'(b + q2);
    endtask
    task automatic count_trig();
        n = 0;
        repeat (12) begin
            @(posedge core_clk_i);
            #1;
            if (trig === 1'b1) n++;
        end
    endtask
    // Reference model: adjusted direction against the edge code
    function automatic int exp_fire(input int cd, input int iv,
                                    input int up);
        int adj;
        adj = up ^ iv;
        return int'(cd == 3 || (cd == 1 && adj == 1) ||
                    (cd == 2 && adj == 0));
    endfunction
    task automatic end_sim();
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Whole run is a few hundred cycles
    initial begin
        #200000;
        fails++;
        end_sim();
    end
    initial begin
        {wr, rd, addr, wdata, p1, vr, n1, n2} = '0;
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        br(CONTROL_ADDR);
        `CHK("ctrl_reset", 0, d)
        bw(CONTROL_ADDR, 16'h7EFF);
        br(CONTROL_ADDR);
        `CHK("ctrl_mask", 16'h66D3, d)
        br(4'h2);
        `CHK("unmapped", 0, d)
        for (int k = 0; k < 8; k++) begin
            inv = k / 4;
            code = k % 4;
            set_in(0, 0, 32, 0);
            bw(CONTROL_ADDR, 16'(32'h8000 | inv << 13 | code << 6));
            // Stale synchroniser contents may fire once after enable
            repeat (8) @(posedge core_clk_i);
            bw(CONTROL_ADDR, 16'(32'h8000 | inv << 13 | code << 6));
            bw(IRQ_CLEAR_ADDR, 16'h0001);
            bw(IRQ_ENABLE_ADDR, 16'(inv));
            e1 = exp_fire(code, inv, 1);
            e2 = e1 ? 0 : exp_fire(code, inv, 0);
            set_in(64, 0, 32, 0);
            count_trig();
            `CHK("trig_rise", e1, n)
            `CHK("irq", 1'(e1 & inv), irq)
            br(CONTROL_ADDR);
            `CHK("flag", 1'(e1), d[9])
            `CHK("result", 1'(!inv), d[8])
            br(IRQ_STATUS_ADDR);
            `CHK("status", e1, d)
            set_in(0, 0, 32, 0);
            count_trig();
            `CHK("trig_fall", e2, n)
            bw(IRQ_CLEAR_ADDR, 16'h0001);
            br(IRQ_STATUS_ADDR);
            `CHK("status_clr", 0, d)
            `CHK("irq_clr", 1'b0, irq)
        end
        set_in(10, 50, 90, 20);
        for (int j = 0; j < 4; j++) begin
            bw(CONTROL_ADDR, 16'(32'h8000 | tbl[j][2] << 4 | tbl[j][1:0]));
            repeat (8) @(posedge core_clk_i);
            br(CONTROL_ADDR);
            `CHK("route", 1'(j == 0 || j == 3), d[8])
        end
        set_in(64, 0, 32, 0);
        bw(CONTROL_ADDR, 16'hC000);
        repeat (8) @(posedge core_clk_i);
        #1;
        `CHK("pin_oe", 2'b01, {oe_n, pin})
        bw(CONTROL_ADDR, 16'hE000);
        repeat (8) @(posedge core_clk_i);
        #1;
        `CHK("pin_inv", 2'b00, {oe_n, pin})
        bw(CONTROL_ADDR, 16'hC400);
        repeat (4) @(posedge core_clk_i);
        #1;
        `CHK("pin_amp", 2'b10, {oe_n, pin})
        bw(CONTROL_ADDR, 16'h40C0);
        count_trig();
        `CHK("off_trig", 0, n)
        br(CONTROL_ADDR);
        `CHK("off_ctrl", 16'h40C0, d)
        `CHK("off_pin", 1'b1, oe_n)
        end_sim();
    end
endmodule // cmpev_top_tb
bind cmpev_top cmpev_chk cmpev_chk_inst (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
    .raw_compare_i(raw_compare_i),
    .comparator_output_pin_o(comparator_output_pin_o),
    .comparator_output_pin_oe_n_o(comparator_output_pin_oe_n_o),
    .analog_ctrl_o(analog_ctrl_o), .trigger_o(trigger_o), .irq_o(irq_o));
`default_nettype wire
